// ==== rtl/lsoc_pkg.sv ====
// Purpose: shared constants, types and compare helpers for the limit switch output unit
// Assumes: word addressed register port, one 32-bit word per register
// Notes: point registers sit at index point*8 + slot; status words above them
package lsoc_pkg;

    localparam int NPOINTS = 32;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 32;
    localparam int TGT_W = 5;

    // register slots inside one point
    localparam logic [2:0] SLOT_ON_LO = 3'h0;
    localparam logic [2:0] SLOT_ON_HI = 3'h1;
    localparam logic [2:0] SLOT_OFF_LO = 3'h2;
    localparam logic [2:0] SLOT_OFF_HI = 3'h3;
    localparam logic [2:0] SLOT_WATCH_LO = 3'h4;
    localparam logic [2:0] SLOT_WATCH_HI = 3'h5;
    localparam logic [2:0] SLOT_CTRL = 3'h6;

    localparam logic [ADDR_W-1:0] STATUS_IDX = 9'h100;
    localparam logic [ADDR_W-1:0] OUTS_IDX = 9'h101;

    // watch value formats
    localparam logic [1:0] FMT_I16 = 2'h0;
    localparam logic [1:0] FMT_I32 = 2'h1;
    localparam logic [1:0] FMT_F64 = 2'h2;

    localparam int CTRL_W = 11;
    localparam logic [63:0] KEY_MSB = 64'h8000000000000000;

    typedef struct packed {
        logic force_bit;
        logic force_set;
        logic en_bit;
        logic en_set;
        logic [1:0] fmt;
        logic [TGT_W-1:0] target;
    } lsoc_ctrl_t;

    typedef struct packed {
        logic [63:0] on_v;
        logic [63:0] off_v;
        logic [63:0] watch;
        lsoc_ctrl_t ctrl;
    } lsoc_pt_t;

    localparam lsoc_pt_t PT_RESET = '0;

    // maps a signed value of any format onto an unsigned ordered key
    function automatic logic [63:0] lsoc_key(input logic [63:0] v, input logic [1:0] fmt);
        logic [63:0] k;
        k = '0;
        case (fmt)
            FMT_I16: k = {{48{v[15]}}, v[15:0]} ^ KEY_MSB;
            FMT_F64: k = v[63] ? ~v : (v ^ KEY_MSB);
            default: k = {{32{v[31]}}, v[31:0]} ^ KEY_MSB;
        endcase
        return k;
    endfunction : lsoc_key

    // window result of one point; equal thresholds never turn on
    function automatic logic lsoc_region(input lsoc_pt_t p);
        logic [63:0] kon;
        logic [63:0] koff;
        logic [63:0] kw;
        logic r;
        kon = lsoc_key(p.on_v, p.ctrl.fmt);
        koff = lsoc_key(p.off_v, p.ctrl.fmt);
        kw = lsoc_key(p.watch, p.ctrl.fmt);
        r = 1'b0;
        if (kon < koff) begin
            r = (kw >= kon) && (kw < koff);
        end else if (kon > koff) begin
            r = (kw >= kon) || (kw < koff);
        end
        return r;
    endfunction : lsoc_region

endpackage : lsoc_pkg

// ==== rtl/lsoc_top.sv ====
// Purpose: limit switch output unit, 32 window compare points ORed onto 32 output bits
// Assumes: OP_TICK is a one-cycle pulse from logic on CLK_SYS; HOST_READY is asynchronous
// Notes: software sees thresholds live; the compare works on a copy taken each tick
//
// Contract
// RULE_01: thirty-two points independent of axis count
// RULE_02: thresholds and watch compared as signed
// RULE_03: on below off: on<=watch<off
// RULE_04: on above off: watch>=on or watch<off
// RULE_05: equal thresholds keep output off
// RULE_06: host ready rise arms, outputs evaluated while ready
// RULE_07: ready falling drives all outputs low
// RULE_08: thresholds copied at ready rise, then each cycle
// RULE_09: points sharing one bit are ORed
// RULE_10: assigned enable low forces point result low
// RULE_11: unassigned enable means always enabled
// RULE_12: force high sets output, beats enable low
// RULE_13: unassigned force never forces output high
// RULE_14: mixed points on one bit are ORed
// RULE_15: outputs refreshed, settings fetched once per cycle
// RULE_16: sixteen, thirty-two bit integer or double format
// RULE_17: host keeps physical inputs out of targets
// RULE_18: host avoids reserved relay addresses as targets
// RULE_19: each target is a single bit address
// RULE_20: outputs registered on tick, low at reset
//
// Local design decisions: the plain strobed port and the register addresses.
module lsoc_top (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic HOST_READY,
    input wire logic OP_TICK,
    input wire logic [lsoc_pkg::ADDR_W-1:0] ADDR,
    input wire logic [lsoc_pkg::DATA_W-1:0] WR_DATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [lsoc_pkg::DATA_W-1:0] RD_DATA,
    output logic MOTION_CPU_READY,
    output logic [lsoc_pkg::NPOINTS-1:0] OUT_BITS
);

    ////////////////////////////////////////////////////////////////////////////////
    // host ready synchroniser and edge

    logic hr_s1_r;
    logic hr_s2_r;
    logic hr_d_r;
    logic ready_r;
    logic ready_nxt;
    logic ready_rise;
    logic load;

    assign ready_rise = hr_s2_r && !hr_d_r;
    // a copy is taken at arming so the first tick already sees valid windows
    assign load = ready_rise || OP_TICK; // [RULE_08]

    always_comb begin
        ready_nxt = hr_s2_r; // [RULE_06] [RULE_07]
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            hr_s1_r <= 1'b0;
            hr_s2_r <= 1'b0;
            hr_d_r <= 1'b0;
            ready_r <= 1'b0;
        end else begin
            hr_s1_r <= HOST_READY;
            hr_s2_r <= hr_s1_r;
            hr_d_r <= hr_s2_r;
            ready_r <= ready_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // live point registers written by software

    lsoc_pkg::lsoc_pt_t pts_r [lsoc_pkg::NPOINTS];
    lsoc_pkg::lsoc_pt_t pts_nxt [lsoc_pkg::NPOINTS];
    logic [4:0] wr_pt;
    logic [2:0] wr_slot;

    assign wr_pt = ADDR[7:3];
    assign wr_slot = ADDR[2:0];

    always_comb begin
        pts_nxt = pts_r;
        if (WR_STB && !ADDR[8]) begin // [RULE_01]
            case (wr_slot)
                lsoc_pkg::SLOT_ON_LO: pts_nxt[wr_pt].on_v[31:0] = WR_DATA;
                lsoc_pkg::SLOT_ON_HI: pts_nxt[wr_pt].on_v[63:32] = WR_DATA;
                lsoc_pkg::SLOT_OFF_LO: pts_nxt[wr_pt].off_v[31:0] = WR_DATA;
                lsoc_pkg::SLOT_OFF_HI: pts_nxt[wr_pt].off_v[63:32] = WR_DATA;
                lsoc_pkg::SLOT_WATCH_LO: pts_nxt[wr_pt].watch[31:0] = WR_DATA;
                lsoc_pkg::SLOT_WATCH_HI: pts_nxt[wr_pt].watch[63:32] = WR_DATA;
                lsoc_pkg::SLOT_CTRL: begin
                    pts_nxt[wr_pt].ctrl = lsoc_pkg::lsoc_ctrl_t'(WR_DATA[lsoc_pkg::CTRL_W-1:0]);
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            pts_r <= '{default: lsoc_pkg::PT_RESET};
        end else begin
            pts_r <= pts_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // working copy fetched once per operation cycle

    lsoc_pkg::lsoc_pt_t sh_r [lsoc_pkg::NPOINTS];
    lsoc_pkg::lsoc_pt_t sh_nxt [lsoc_pkg::NPOINTS];

    always_comb begin
        sh_nxt = sh_r;
        if (load) begin
            sh_nxt = pts_r; // [RULE_08] [RULE_15]
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            sh_r <= '{default: lsoc_pkg::PT_RESET};
        end else begin
            sh_r <= sh_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // point results and OR onto targets

    logic [lsoc_pkg::NPOINTS-1:0] pres;
    logic [lsoc_pkg::NPOINTS-1:0] eval_v;

    always_comb begin
        pres = '0;
        eval_v = '0;
        for (int i = 0; i < lsoc_pkg::NPOINTS; i++) begin
            if (sh_r[i].ctrl.force_set && sh_r[i].ctrl.force_bit) begin
                pres[i] = 1'b1; // [RULE_12] [RULE_13]
            end else if (!sh_r[i].ctrl.en_set || sh_r[i].ctrl.en_bit) begin
                // [RULE_02] [RULE_03] [RULE_04] [RULE_05] [RULE_16]
                pres[i] = lsoc_pkg::lsoc_region(sh_r[i]); // [RULE_10] [RULE_11]
            end
            // targets are single bits chosen by the host [RULE_19]
            eval_v[sh_r[i].ctrl.target] = eval_v[sh_r[i].ctrl.target] | pres[i]; // [RULE_09] [RULE_14]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // output register

    logic [lsoc_pkg::NPOINTS-1:0] out_r;
    logic [lsoc_pkg::NPOINTS-1:0] out_nxt;

    always_comb begin
        out_nxt = out_r;
        if (!ready_r) begin
            out_nxt = '0; // [RULE_07]
        end else if (OP_TICK) begin
            out_nxt = eval_v; // [RULE_06] [RULE_15] [RULE_20]
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            out_r <= '0; // [RULE_20]
        end else begin
            out_r <= out_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read port, data valid the cycle after the strobe only

    logic [lsoc_pkg::DATA_W-1:0] rdata_r;
    logic [lsoc_pkg::DATA_W-1:0] rdata_nxt;
    lsoc_pkg::lsoc_pt_t rp;

    always_comb begin
        rdata_nxt = '0;
        rp = pts_r[wr_pt];
        if (RD_STB) begin
            if (!ADDR[8]) begin
                case (wr_slot)
                    lsoc_pkg::SLOT_ON_LO: rdata_nxt = rp.on_v[31:0];
                    lsoc_pkg::SLOT_ON_HI: rdata_nxt = rp.on_v[63:32];
                    lsoc_pkg::SLOT_OFF_LO: rdata_nxt = rp.off_v[31:0];
                    lsoc_pkg::SLOT_OFF_HI: rdata_nxt = rp.off_v[63:32];
                    lsoc_pkg::SLOT_WATCH_LO: rdata_nxt = rp.watch[31:0];
                    lsoc_pkg::SLOT_WATCH_HI: rdata_nxt = rp.watch[63:32];
                    lsoc_pkg::SLOT_CTRL: rdata_nxt = {21'h000000, rp.ctrl};
                    default: rdata_nxt = '0;
                endcase
            end else if (ADDR == lsoc_pkg::STATUS_IDX) begin
                rdata_nxt = {31'h00000000, ready_r};
            end else if (ADDR == lsoc_pkg::OUTS_IDX) begin
                rdata_nxt = out_r;
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign RD_DATA = rdata_r;
    assign MOTION_CPU_READY = ready_r;
    assign OUT_BITS = out_r;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    sequence arm_s;
        !hr_s2_r ##1 hr_s2_r;
    endsequence

    ready_arm_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_06]
        arm_s |=> ready_r && MOTION_CPU_READY)
        else $error("ready flag not raised after host arming");

    ready_drop_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_07]
        $fell(hr_s2_r) |=> !ready_r ##1 (OUT_BITS == '0))
        else $error("outputs not cleared after ready fell");

    shadow_load_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_08]
        load |=> (sh_r[0] == $past(pts_r[0])) && (sh_r[31] == $past(pts_r[31])))
        else $error("working copy not fetched");

    shadow_hold_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_15]
        !load |=> $stable(sh_r[0]))
        else $error("working copy changed between ticks");

    out_hold_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_20]
        (!OP_TICK && ready_r) |=> $stable(OUT_BITS))
        else $error("outputs changed without a tick");

    force_wins_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_12]
        (OP_TICK && ready_r && sh_r[0].ctrl.force_set && sh_r[0].ctrl.force_bit)
        |=> OUT_BITS[$past(sh_r[0].ctrl.target)])
        else $error("forced point did not drive its bit");

    equal_off_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_05]
        (sh_r[0].on_v == sh_r[0].off_v && !sh_r[0].ctrl.force_set) |-> !pres[0])
        else $error("equal thresholds gave an on result");

    enable_low_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_10]
        (sh_r[0].ctrl.en_set && !sh_r[0].ctrl.en_bit && !sh_r[0].ctrl.force_bit) |-> !pres[0])
        else $error("disabled point gave an on result");

    or_merge_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_09]
        (OP_TICK && ready_r && pres[1]) |=> OUT_BITS[$past(sh_r[1].ctrl.target)])
        else $error("point result missing from its target bit");

    status_read_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_06]
        (RD_STB && ADDR == lsoc_pkg::STATUS_IDX) |=> RD_DATA == {31'h00000000, $past(ready_r)})
        else $error("status read wrong");

    idle_read_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_15]
        !RD_STB |=> RD_DATA == '0)
        else $error("read data present without a strobe");

endmodule : lsoc_top

// ==== verif/lsoc_host_model.sv ====
// Purpose: host controller model, drives the ready flag and the register port
// Assumes: one request per call, strobes one cycle, changes right after a rising edge
// Notes: after a strobe the address lines show an inverted copy; write data is inverted only after a write
module lsoc_host_model (
    input wire logic clk,
    output logic host_ready,
    output logic [lsoc_pkg::ADDR_W-1:0] addr,
    output logic [lsoc_pkg::DATA_W-1:0] wr_data,
    output logic wr_stb,
    output logic rd_stb,
    input wire logic [lsoc_pkg::DATA_W-1:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        host_ready = 1'b0;
        addr = '0;
        wr_data = '0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic set_ready(input logic v);
        @(posedge clk);
        host_ready <= v;
    endtask : set_ready

    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        addr <= ~a;
        wr_data <= ~d;
    endtask : wr

    task automatic rd(input logic [8:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        addr <= ~a;
        #1 d = rd_data;
    endtask : rd

    // target field is five bits: one output bit, never an input-only range
    task automatic wr_point(input int p, input logic [63:0] on_v, input logic [63:0] off_v,
                            input logic [63:0] w_v, input lsoc_pkg::lsoc_ctrl_t c);
        logic [8:0] b;
        logic [31:0] w [7];
        b = 9'(p * 8);
        w = '{on_v[31:0], on_v[63:32], off_v[31:0], off_v[63:32], w_v[31:0], w_v[63:32], 32'(c)};
        for (int s = 0; s < 7; s++) wr(b + 9'(s), w[s]);
    endtask : wr_point
endmodule : lsoc_host_model

// ==== verif/tb.sv ====
// Purpose: self-checking bench for the limit switch output unit
// Assumes: host model owns the register port, bench owns the tick
// Notes: small threshold range so equal and boundary cases come up often
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); err_total++; end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys, rst, host_ready, op_tick, wr_stb, rd_stb, motion_cpu_ready;
    logic [8:0] addr;
    logic [31:0] wr_data, rd_data, out_bits, d;
    int err_total, checks_done, cyc;
    int on_i [32], off_i [32], w_i [32];
    lsoc_pkg::lsoc_ctrl_t ctl [32];

    lsoc_top u_dut (.CLK_SYS(clk_sys), .RST(rst), .HOST_READY(host_ready), .OP_TICK(op_tick),
        .ADDR(addr), .WR_DATA(wr_data), .WR_STB(wr_stb), .RD_STB(rd_stb), .RD_DATA(rd_data),
        .MOTION_CPU_READY(motion_cpu_ready), .OUT_BITS(out_bits));
    lsoc_host_model u_host (.clk(clk_sys), .host_ready(host_ready), .addr(addr),
        .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data));

    ////////////////////////////////////////////////////////////////////////
    // upper bits of integer formats are junk on purpose
    function automatic logic [63:0] enc(input int v, input logic [1:0] f);
        logic [31:0] j;
        j = $urandom;
        if (f == lsoc_pkg::FMT_F64) return $realtobits(real'(v));
        if (f == lsoc_pkg::FMT_I16) return {j, j[31:16], v[15:0]};
        return {j, v};
    endfunction : enc

    function automatic logic [31:0] expect_outs();
        logic [31:0] o;
        logic r, en;
        o = '0;
        for (int p = 0; p < 32; p++) begin
            r = (on_i[p] < off_i[p]) ? (w_i[p] >= on_i[p] && w_i[p] < off_i[p]) :
                (on_i[p] > off_i[p]) ? (w_i[p] >= on_i[p] || w_i[p] < off_i[p]) : 1'b0;
            en = ctl[p].en_set ? ctl[p].en_bit : 1'b1;
            if ((ctl[p].force_set && ctl[p].force_bit) || (en && r)) o[ctl[p].target] = 1'b1;
        end
        return o;
    endfunction : expect_outs

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            op_tick <= 1'b1;
            @(posedge clk_sys);
            op_tick <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
        #1;
    endtask : tick

    task automatic close_out();
        if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            close_out();
        end
    end

    initial begin
        rst = 1'b1;
        op_tick = 1'b0;
        foreach (ctl[p]) ctl[p] = '0;
        void'($urandom(32'h77C53E8B));
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        #1 `CHK("outs at reset", 32'h0, out_bits)
        // thresholds written before arming are copied by the unarmed tick and must show at the first armed tick
        on_i[0] = -5;
        off_i[0] = 10;
        w_i[0] = -5;
        ctl[0].fmt = lsoc_pkg::FMT_I32;
        ctl[0].target = 5'h3;
        u_host.wr_point(0, enc(-5, 2'h1), enc(10, 2'h1), enc(-5, 2'h1), ctl[0]);
        tick(1);
        `CHK("outs unarmed", 32'h0, out_bits)
        u_host.set_ready(1'b1);
        repeat (5) @(posedge clk_sys);
        #1 `CHK("ready flag", 1'b1, motion_cpu_ready)
        u_host.rd(lsoc_pkg::STATUS_IDX, d);
        `CHK("status", 32'h1, d)
        tick(1);
        `CHK("outs at arm", 32'h8, out_bits)
        repeat (24) begin
            for (int p = 0; p < 32; p++) begin
                on_i[p] = int'($urandom_range(6)) - 3;
                off_i[p] = int'($urandom_range(6)) - 3;
                w_i[p] = int'($urandom_range(6)) - 3;
                ctl[p] = lsoc_pkg::lsoc_ctrl_t'(11'($urandom));
                ctl[p].fmt = 2'($urandom_range(2));
                u_host.wr_point(p, enc(on_i[p], ctl[p].fmt), enc(off_i[p], ctl[p].fmt),
                                enc(w_i[p], ctl[p].fmt), ctl[p]);
            end
            tick(2);
            `CHK("outs", expect_outs(), out_bits)
            u_host.rd(lsoc_pkg::OUTS_IDX, d);
            `CHK("outs word", expect_outs(), d)
            u_host.rd(9'h0FE, d);
            `CHK("ctrl readback", 32'(ctl[31]), d)
            u_host.rd(9'h1FF, d);
            `CHK("unmapped read", 32'h0, d)
        end
        u_host.set_ready(1'b0);
        repeat (6) @(posedge clk_sys);
        #1 `CHK("ready cleared", 1'b0, motion_cpu_ready)
        `CHK("outs cleared", 32'h0, out_bits)
        tick(2);
        `CHK("outs stay low", 32'h0, out_bits)
        close_out();
    end
endmodule : tb
